/* File: rtl/admc_mode_regs.sv */
/*
 * mode-control register bank of a stereo audio dac. holds filter, mute,
 * interface-mode, monaural_enable and modulator-rate controls, the zero-flag enables,
 * the zero-detect status and the command-mode identifier.
 * assumes the serial control front end hands over each 16-bit control word
 * as one strobe on clk, and takes read data back the cycle after the read command.
 * zero detections come from the datapath on clk; pin-level inputs are
 * synchronised here.
 */
// Functional notes
// RULE_01: bypass stereo bit clear means monaural_enable from single data pin; set means stereo.
// RULE_02: stereo bypass takes left and right samples on the two zero pins.
// RULE_03: roll-off bit picks sharp response at 0 and slow at 1.
// RULE_04: infinite-zero mute with zero on both channels holds outputs at bipolar zero.
// RULE_05: infinite-zero mute never acts while bitstream mode is on.
// RULE_06: word bit 15 zero writes, one reads back; default write.
// RULE_07: writing one to soft reset gives one reset pulse; bit is write-only.
// RULE_08: bitstream mode bit B5 disables at 0, enables at 1.
// RULE_09: filter bypass bit B4 keeps internal filter at 0, bypasses at 1.
// RULE_10: monaural bit drives both converters balanced from one channel.
// RULE_11: channel select picks left or right, only while monaural is set.
// RULE_12: rate field 00 gives 64 fS, 01 32 fS, 10 128 fS; 11 reserved.
// RULE_13: host avoids 128 fS above 100 kHz and supplies clock over 256 fS.
// RULE_14: in bitstream mode the rate field selects the stream bit-clock speed.
// RULE_15: stream zero field 00 disables flags; nonzero picks even or 96h detect.
// RULE_16: pcm zero enable, default 1, gates flags in pcm and external filter modes.
// RULE_17: status bits read 1 on zero detect, mirroring the zero flag pins.
// RULE_18: status and identifier registers are read only; writes are dropped.
// RULE_19: five-bit identifier field reports the command-and-audio device id.
// RULE_20: external filter mode only when bitstream is 0 and filter bypass is 1.
// RULE_21: host runs the word clock at 8 or 4 times sampling rate.
// RULE_22: word is direction bit 15, index 14..8, data 7..0.
// RULE_23: reserved bits and reserved rate code are ignored on write; code stores a reserved rate code, only the decoded rate holds.
`timescale 1ns/100ps

module admc_mode_regs
	import admc_pkg::*;
#(
	parameter logic [4:0] DEVICE_ID = DEFAULT_ID // arbitrary neutral value
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control word port
	input  wire logic        cmdValid,
	input  wire logic [15:0] cmdWord,
	output logic             readValid,
	output logic [15:0]      readWord,
	// zero detections from the datapath
	input  wire logic        leftZeroDetect,
	input  wire logic        rightZeroDetect,
	// zero pins that double as stereo bypass data inputs, and the single data pin
	input  wire logic        leftZeroPinIn,
	input  wire logic        rightZeroPinIn,
	input  wire logic        singleDataPin,
	// zero flag pins, driven unless used as inputs
	output logic             leftZeroPin,
	output logic             rightZeroPin,
	output logic             leftZeroPinOe,
	output logic             rightZeroPinOe,
	// decoded controls to the datapath
	output logic             softResetPulse,
	output logic             rolloffSlow,
	output logic             bitstreamMode,
	output logic             externalFilterMode,
	output logic             internalFilterOn,
	output logic [1:0]       modulatorRate,
	output logic [1:0]       bitClockSpeed,
	output logic [1:0]       converterSource,
	output logic             bipolarZeroHold,
	output logic             bypassLeftData,
	output logic             bypassRightData,
	output logic [1:0]       bitstreamZeroMode
);

	// ****************************************************************
	// register storage
	// ****************************************************************
	logic [7:0] modeSelect;
	logic [7:0] zeroEnable;
	logic [7:0] filterCtrl;
	logic       leftSync1;
	logic       leftSync2;
	logic       rightSync1;
	logic       rightSync2;
	logic       dataSync1;
	logic       dataSync2;

	logic       cmdRead;
	logic       cmdWrite;
	logic [6:0] cmdIndex;
	logic [7:0] cmdData;
	logic       softResetReq;

	assign cmdRead  = cmdValid && cmdWord[DIR_BIT];  // [RULE_06]
	assign cmdWrite = cmdValid && !cmdWord[DIR_BIT]; // [RULE_06]
	assign cmdIndex = cmdWord[INDEX_HI:INDEX_LO];    // [RULE_22]
	assign cmdData  = cmdWord[DATA_HI:DATA_LO];      // [RULE_22]
	assign softResetReq = cmdWrite && cmdIndex == IDX_MODE_SELECT
		&& cmdData[POS_SOFT_RESET]; // [RULE_07]

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		leftSync1  <= leftZeroPinIn;
		leftSync2  <= leftSync1;
		rightSync1 <= rightZeroPinIn;
		rightSync2 <= rightSync1;
		dataSync1  <= singleDataPin;
		dataSync2  <= dataSync1;
	end

	// ****************************************************************
	// register writes
	// ****************************************************************
	// the soft reset pulse also returns the bank to its initial condition,
	// so a write carrying soft reset keeps none of its other bits
	always_ff @(posedge clk)
	begin
		if (rst || softResetPulse)
		begin
			modeSelect <= RST_MODE_SELECT;
			zeroEnable <= RST_ZERO_ENABLE;
			filterCtrl <= RST_FILTER_CTRL;
		end
		else if (cmdWrite && !softResetReq)
		begin
			case (cmdIndex)
				IDX_MODE_SELECT:
					modeSelect <= cmdData & MASK_MODE_STORE; // [RULE_23]
				IDX_ZERO_ENABLE:
					zeroEnable <= cmdData & MASK_ZERO_EN;    // [RULE_23]
				IDX_FILTER_CTRL:
					filterCtrl <= cmdData & MASK_FILTER;
				// status and identifier take no writes
				default:
					modeSelect <= modeSelect; // [RULE_18]
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			softResetPulse <= 1'b0;
		else
			softResetPulse <= softResetReq && !softResetPulse; // [RULE_07]
	end

	// ****************************************************************
	// readback
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			readValid <= 1'b0;
			readWord  <= 16'h0000;
		end
		else
		begin
			readValid <= cmdRead;
			if (cmdRead)
			begin
				readWord[DIR_BIT]           <= 1'b1;
				readWord[INDEX_HI:INDEX_LO] <= cmdIndex;
				case (cmdIndex)
					// soft reset reads back as zero
					IDX_MODE_SELECT:
						readWord[DATA_HI:DATA_LO] <= modeSelect & MASK_MODE_STORE
							& ~(8'h01 << POS_SOFT_RESET); // [RULE_07]
					IDX_ZERO_ENABLE:
						readWord[DATA_HI:DATA_LO] <= zeroEnable;
					IDX_FILTER_CTRL:
						readWord[DATA_HI:DATA_LO] <= filterCtrl;
					IDX_ZERO_STATUS:
						readWord[DATA_HI:DATA_LO] <= {6'h00, rightZeroPin,
							leftZeroPin}; // [RULE_17]
					IDX_IDENTIFIER:
						readWord[DATA_HI:DATA_LO] <= {3'h0, DEVICE_ID}; // [RULE_19]
					default:
						readWord[DATA_HI:DATA_LO] <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************************************
	// mode decode
	// ****************************************************************
	logic nextExternal;
	logic nextBitstream;
	logic stereoBypass;
	logic zeroFlagsOn;
	logic [1:0] next_source;

	assign nextBitstream = modeSelect[POS_BITSTREAM];                    // [RULE_08]
	assign nextExternal  = !nextBitstream && modeSelect[POS_FILTER_BYP]; // [RULE_20]
	assign stereoBypass  = nextExternal && filterCtrl[POS_STEREO_BYP];   // [RULE_02]
	assign zeroFlagsOn   = nextBitstream ? (zeroEnable[POS_ZMODE_HI:POS_ZMODE_LO] != 2'h0)
		: zeroEnable[POS_PCM_ZERO]; // [RULE_15] [RULE_16]

	always_comb
	begin
		if (nextExternal && !filterCtrl[POS_STEREO_BYP])
			next_source = SRC_SINGLE_PIN; // [RULE_01]
		else if (modeSelect[POS_MONAURAL])
			next_source = modeSelect[POS_CHANNEL_SEL] ? SRC_MONAURAL_ENABLE_RIGHT
				: SRC_MONAURAL_ENABLE_LEFT; // [RULE_10] [RULE_11]
		else
			next_source = SRC_STEREO;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rolloffSlow        <= 1'b0;
			bitstreamMode      <= 1'b0;
			externalFilterMode <= 1'b0;
			internalFilterOn   <= 1'b1;
			modulatorRate      <= RATE_64FS;
			bitClockSpeed      <= 2'h0;
			converterSource    <= SRC_STEREO;
			bitstreamZeroMode  <= ZMODE_OFF;
		end
		else
		begin
			rolloffSlow        <= filterCtrl[POS_ROLLOFF];      // [RULE_03]
			bitstreamMode      <= nextBitstream;                // [RULE_08]
			externalFilterMode <= nextExternal;                 // [RULE_20]
			internalFilterOn   <= !modeSelect[POS_FILTER_BYP];  // [RULE_09]
			// reserved rate code leaves the rate unchanged
			if (modeSelect[POS_RATE_HI:POS_RATE_LO] != RATE_RSVD) // [RULE_23]
			begin
				if (nextBitstream)
					bitClockSpeed <= modeSelect[POS_RATE_HI:POS_RATE_LO]; // [RULE_14]
				else
					modulatorRate <= modeSelect[POS_RATE_HI:POS_RATE_LO]; // [RULE_12]
			end
			converterSource    <= next_source;
			bitstreamZeroMode  <= nextBitstream ? zeroEnable[POS_ZMODE_HI:POS_ZMODE_LO]
				: ZMODE_OFF; // [RULE_15]
		end
	end

	// ****************************************************************
	// zero flags, mute and bypass data
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			leftZeroPin     <= 1'b0;
			rightZeroPin    <= 1'b0;
			leftZeroPinOe   <= 1'b1;
			rightZeroPinOe  <= 1'b1;
			bipolarZeroHold <= 1'b0;
			bypassLeftData  <= 1'b0;
			bypassRightData <= 1'b0;
		end
		else
		begin
			// flags read 0 when disabled or when the pins carry data
			leftZeroPin     <= zeroFlagsOn && !stereoBypass && leftZeroDetect;  // [RULE_17]
			rightZeroPin    <= zeroFlagsOn && !stereoBypass && rightZeroDetect; // [RULE_17]
			leftZeroPinOe   <= !stereoBypass;  // [RULE_02]
			rightZeroPinOe  <= !stereoBypass;  // [RULE_02]
			bipolarZeroHold <= filterCtrl[POS_INF_MUTE] && !nextBitstream
				&& leftZeroDetect && rightZeroDetect; // [RULE_04] [RULE_05]
			bypassLeftData  <= stereoBypass ? leftSync2 : dataSync2;   // [RULE_01]
			bypassRightData <= stereoBypass ? rightSync2 : dataSync2;  // [RULE_02]
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_soft_reset_once: assert property (@(posedge clk) disable iff (rst)
		softResetPulse |=> !softResetPulse) // [RULE_07]
		else $error("soft reset pulse longer than one cycle");

	a_soft_reset_cause: assert property (@(posedge clk) disable iff (rst)
		softResetReq && !softResetPulse |=> softResetPulse) // [RULE_07]
		else $error("soft reset write gave no pulse");

	a_mute_not_bitstream: assert property (@(posedge clk) disable iff (rst)
		bipolarZeroHold |-> $past(!modeSelect[POS_BITSTREAM])) // [RULE_05]
		else $error("zero mute active in bitstream mode");

	a_mute_both_zero: assert property (@(posedge clk) disable iff (rst)
		filterCtrl[POS_INF_MUTE] && !nextBitstream && leftZeroDetect && rightZeroDetect
		&& !softResetPulse |=> bipolarZeroHold) // [RULE_04]
		else $error("zero mute missed");

	a_read_answer: assert property (@(posedge clk) disable iff (rst)
		cmdRead |=> readValid && readWord[DIR_BIT]) // [RULE_06]
		else $error("readback not answered");

	a_status_ro: assert property (@(posedge clk) disable iff (rst)
		cmdWrite && cmdIndex == IDX_ZERO_STATUS && !softResetPulse |=> $stable(modeSelect)
		&& $stable(zeroEnable)) // [RULE_18]
		else $error("status write changed a register");

	a_ext_filter: assert property (@(posedge clk) disable iff (rst)
		externalFilterMode |-> !bitstreamMode) // [RULE_20]
		else $error("external filter with bitstream mode");

	a_flag_gate: assert property (@(posedge clk) disable iff (rst)
		!bitstreamMode && !$past(zeroEnable[POS_PCM_ZERO]) && !$past(nextBitstream)
		|-> !leftZeroPin && !rightZeroPin) // [RULE_16]
		else $error("zero flag while disabled");

	a_rate_64fs: assert property (@(posedge clk) disable iff (rst)
		!nextBitstream && modeSelect[POS_RATE_HI:POS_RATE_LO] == RATE_64FS
		&& !softResetPulse |=> modulatorRate == RATE_64FS) // [RULE_12]
		else $error("modulator rate not applied");

	a_oe_bypass_off: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
		$past(stereoBypass) |-> !leftZeroPinOe && !rightZeroPinOe)
		else $error("zero pin driven while used as input");

	a_zero_enable_write: assert property (@(posedge clk) disable iff (rst) // [RULE_23]
		cmdWrite && cmdIndex == IDX_ZERO_ENABLE && !softResetPulse
		|=> zeroEnable == ($past(cmdData) & MASK_ZERO_EN))
		else $error("zero enable write not stored");

	a_id_read: assert property (@(posedge clk) disable iff (rst) // [RULE_19]
		cmdRead && cmdIndex == IDX_IDENTIFIER |=> readWord[DATA_HI:DATA_LO] == {3'h0, DEVICE_ID})
		else $error("identifier readback wrong");

	a_soft_reset_defaults: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
		softResetPulse |=> modeSelect == RST_MODE_SELECT && zeroEnable == RST_ZERO_ENABLE)
		else $error("soft reset left a register changed");

	a_single_pin_src: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
		$past(nextExternal && !filterCtrl[POS_STEREO_BYP]) |-> converterSource == SRC_SINGLE_PIN)
		else $error("monaural_enable bypass not from single pin");

	a_pcm_flag_on: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
		$past(!nextBitstream && zeroEnable[POS_PCM_ZERO] && !stereoBypass && leftZeroDetect)
		|-> leftZeroPin)
		else $error("enabled zero flag missing");

	a_zmode_bitstream: assert property (@(posedge clk) disable iff (rst) // [RULE_15]
		bitstreamZeroMode != ZMODE_OFF |-> bitstreamMode)
		else $error("stream zero mode outside bitstream mode");

endmodule

/* File: rtl/admc_pkg.sv */
/*
 * package for the audio dac mode-control register bank: control word layout,
 * register indices, field positions, reset values and mode encodings.
 * assumes a 16-bit control word delivered whole by a serial port front end.
 */
package admc_pkg;

	// ****************************************************************
	// control word layout
	// ****************************************************************
	localparam int WORD_BITS      = 16;
	localparam int DIR_BIT        = 15;
	localparam int INDEX_HI       = 14;
	localparam int INDEX_LO       = 8;
	localparam int DATA_HI        = 7;
	localparam int DATA_LO        = 0;

	// ****************************************************************
	// register indices
	// ****************************************************************
	localparam logic [6:0] IDX_MODE_SELECT = 7'h14;
	localparam logic [6:0] IDX_ZERO_ENABLE = 7'h15;
	localparam logic [6:0] IDX_ZERO_STATUS = 7'h16;
	localparam logic [6:0] IDX_IDENTIFIER  = 7'h17;
	localparam logic [6:0] IDX_FILTER_CTRL = 7'h13;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int POS_SOFT_RESET   = 6;
	localparam int POS_BITSTREAM    = 5;
	localparam int POS_FILTER_BYP   = 4;
	localparam int POS_MONAURAL     = 3;
	localparam int POS_CHANNEL_SEL  = 2;
	localparam int POS_RATE_HI      = 1;
	localparam int POS_RATE_LO      = 0;
	localparam int POS_STEREO_BYP   = 2;
	localparam int POS_ROLLOFF      = 1;
	localparam int POS_INF_MUTE     = 0;
	localparam int POS_ZMODE_HI     = 2;
	localparam int POS_ZMODE_LO     = 1;
	localparam int POS_PCM_ZERO     = 0;
	localparam int POS_LEFT_ZERO    = 0;
	localparam int POS_RIGHT_ZERO   = 1;

	// ****************************************************************
	// reset values and write masks
	// ****************************************************************
	localparam logic [7:0] RST_MODE_SELECT = 8'h00;
	localparam logic [7:0] RST_ZERO_ENABLE = 8'h01;
	localparam logic [7:0] RST_FILTER_CTRL = 8'h00;
	localparam logic [7:0] MASK_MODE_STORE = 8'h3f;
	localparam logic [7:0] MASK_ZERO_EN    = 8'h07;
	localparam logic [7:0] MASK_FILTER     = 8'h07;
	localparam logic [4:0] DEFAULT_ID      = 5'h00;

	// ****************************************************************
	// modulator rate codes and stream zero-detect mode codes
	// ****************************************************************
	typedef enum logic [1:0] {
		RATE_64FS  = 2'h0,
		RATE_32FS  = 2'h1,
		RATE_128FS = 2'h2,
		RATE_RSVD  = 2'h3
	} admc_rate_type;

	typedef enum logic [1:0] {
		ZMODE_OFF     = 2'h0,
		ZMODE_EVEN    = 2'h1,
		ZMODE_PATTERN = 2'h2,
		ZMODE_RSVD    = 2'h3
	} admc_zmode_type;

	// data source for the converters
	typedef enum logic [1:0] {
		SRC_STEREO     = 2'h0,
		SRC_MONAURAL_ENABLE_LEFT  = 2'h1,
		SRC_MONAURAL_ENABLE_RIGHT = 2'h3,
		SRC_SINGLE_PIN = 2'h2
	} admc_source_type;

endpackage

/* File: testbench/admc_host.sv */
/*
 * host controller model for the serial control port of the mode-control bank:
 * hands the bank one whole 16-bit control word per call of send.
 * assumes the caller sits just after a rising edge of clk when it calls.
 */
`timescale 1ns/100ps

module admc_host
	import admc_pkg::*;
(
	// clock
	input  wire logic                 clk,
	// control word port
	output logic                      cmdValid,
	output logic [WORD_BITS-1:0]      cmdWord
);
	initial
	begin
		cmdValid = 1'b0;
		cmdWord  = 16'h0000;
	end

	// ****************************************************************
	// transfers
	// ****************************************************************
	// bit 15 picks write or readback, index and data follow
	// modelled sample rate stays low and word clock is not modelled
	task automatic send(input logic [WORD_BITS-1:0] w);
		cmdValid <= 1'b1;
		cmdWord  <= w;
		@(posedge clk);
	endtask

	// released word toggles so a stale word never looks like a fresh one
	task automatic idle();
		cmdValid <= 1'b0;
		cmdWord  <= ~cmdWord;
		@(posedge clk);
	endtask
endmodule

/* File: testbench/admc_mode_regs_bench.sv */
/*
 * self-checking bench for the mode-control register bank: register access,
 * decoded controls, zero flags, stereo bypass pins and soft reset.
 * assumes the host model drives the control port and the bench drives pins.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin numErrors++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

module admc_mode_regs_bench
	import admc_pkg::*;
;
	localparam logic [4:0] ID = 5'h0b; // arbitrary value
	logic        clk, rst, cmdValid, readValid, softResetPulse, rolloffSlow;
	logic [15:0] cmdWord, readWord, e;
	logic        leftZeroDetect, rightZeroDetect, leftZeroPinIn, rightZeroPinIn;
	logic        singleDataPin, leftZeroPin, rightZeroPin, leftZeroPinOe, rightZeroPinOe;
	logic        bitstreamMode, externalFilterMode, internalFilterOn, bipolarZeroHold;
	logic        bypassLeftData, bypassRightData;
	logic [1:0]  modulatorRate, bitClockSpeed, converterSource, bitstreamZeroMode;
	logic [7:0]  shMode, shEn, shFilt, shStat, d;
	logic [31:0] r;
	logic [15:0] expQ[$];
	int          numErrors, checked, seed;

	admc_host host (.clk(clk), .cmdValid(cmdValid), .cmdWord(cmdWord));

	admc_mode_regs #(.DEVICE_ID(ID)) dut (
		.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdWord(cmdWord),
		.readValid(readValid), .readWord(readWord),
		.leftZeroDetect(leftZeroDetect), .rightZeroDetect(rightZeroDetect),
		.leftZeroPinIn(leftZeroPinIn), .rightZeroPinIn(rightZeroPinIn),
		.singleDataPin(singleDataPin), .leftZeroPin(leftZeroPin),
		.rightZeroPin(rightZeroPin), .leftZeroPinOe(leftZeroPinOe),
		.rightZeroPinOe(rightZeroPinOe), .softResetPulse(softResetPulse),
		.rolloffSlow(rolloffSlow), .bitstreamMode(bitstreamMode),
		.externalFilterMode(externalFilterMode), .internalFilterOn(internalFilterOn),
		.modulatorRate(modulatorRate), .bitClockSpeed(bitClockSpeed),
		.converterSource(converterSource), .bipolarZeroHold(bipolarZeroHold),
		.bypassLeftData(bypassLeftData), .bypassRightData(bypassRightData),
		.bitstreamZeroMode(bitstreamZeroMode));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************************************
	// expectations and transfers
	// ****************************************************************
	function automatic logic [7:0] expData(input logic [6:0] idx);
		case (idx)
			IDX_FILTER_CTRL: return shFilt;
			IDX_MODE_SELECT: return shMode;
			IDX_ZERO_ENABLE: return shEn;
			IDX_ZERO_STATUS: return shStat;
			IDX_IDENTIFIER:  return {3'h0, ID};
			default:         return 8'h00;
		endcase
	endfunction

	// shadow follows the write; read-only and unmapped targets keep it unchanged
	task automatic wr(input logic [6:0] idx, input logic [7:0] v);
		host.send({1'b0, idx, v});
		if (idx == IDX_MODE_SELECT && v[POS_SOFT_RESET])
		begin
			shMode = RST_MODE_SELECT;
			shEn   = RST_ZERO_ENABLE;
			shFilt = RST_FILTER_CTRL;
		end
		else if (idx == IDX_MODE_SELECT)
			shMode = {2'h0, v[5:2], (v[1:0] == 2'h3) ? shMode[1:0] : v[1:0]};
		else if (idx == IDX_ZERO_ENABLE)
			shEn = v & MASK_ZERO_EN;
		else if (idx == IDX_FILTER_CTRL)
			shFilt = v & MASK_FILTER;
	endtask

	task automatic rd(input logic [6:0] idx);
		expQ.push_back({1'b1, idx, expData(idx)});
		host.send({1'b1, idx, 8'h00});
	endtask

	task automatic waitc(input int n);
		repeat (n) host.idle();
	endtask

	// decoded controls two cycles after the last write
	task automatic chkMode();
		logic ext;
		waitc(2);
		@(negedge clk);
		ext = ~shMode[5] & shMode[4];
		`CHK(bitstreamMode, shMode[5])
		`CHK(externalFilterMode, ext)
		`CHK(rolloffSlow, shFilt[1])
		if (!shMode[5])
		begin
			`CHK(internalFilterOn, ~shMode[4])
			`CHK(modulatorRate, shMode[1:0])
		end
		else
			`CHK(bitClockSpeed, shMode[1:0])
		if (ext && !shFilt[2] && !shMode[3])
			`CHK(converterSource, SRC_SINGLE_PIN)
		else if (!ext)
			`CHK(converterSource, shMode[3] ? {shMode[2], 1'b1} : SRC_STEREO)
		@(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", numErrors, checked);
		if (numErrors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************************************
	// readback monitor
	// ****************************************************************
	always @(negedge clk)
		if (readValid === 1'b1)
		begin
			e = (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx;
			`CHK(readWord, e)
		end

	initial
	begin
		repeat (20000) @(posedge clk);
		numErrors++;
		$display("Error at %0t: run limit reached", $time);
		report_and_stop();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		seed = 27;
		numErrors = 0;
		checked = 0;
		rst = 1'b1;
		{leftZeroDetect, rightZeroDetect, leftZeroPinIn, rightZeroPinIn} = 4'h0;
		singleDataPin = 1'b0;
		{shMode, shEn, shFilt, shStat} = {RST_MODE_SELECT, RST_ZERO_ENABLE, RST_FILTER_CTRL, 8'h00};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		host.idle();
		`CHK(leftZeroPinOe, 1'b1)
		chkMode();
		for (int i = 0; i < 5; i++)
			rd(IDX_FILTER_CTRL + 7'(i));
		wr(IDX_ZERO_STATUS, 8'hff);
		wr(IDX_IDENTIFIER, 8'hff);
		wr(7'h20, 8'hff);
		for (int i = 0; i < 5; i++)
			rd(IDX_FILTER_CTRL + 7'(i));
		for (int i = 0; i < 12; i++)
		begin
			r = $random(seed);
			d = r[7:0];
			if (i < 3)
				d[1:0] = 2'(i);
			// the random mode writes never carry the reserved rate code
			if (d[1:0] == 2'h3)
				d[1:0] = 2'h2;
			d[POS_SOFT_RESET] = 1'b0;
			wr(IDX_MODE_SELECT, d);
			wr(IDX_FILTER_CTRL, r[15:8]);
			rd(IDX_MODE_SELECT);
			rd(IDX_FILTER_CTRL);
			chkMode();
		end
		wr(IDX_MODE_SELECT, 8'h00);
		wr(IDX_FILTER_CTRL, 8'h01);
		leftZeroDetect <= 1'b1;
		waitc(6);
		`CHK(leftZeroPin, 1'b1)
		`CHK(bipolarZeroHold, 1'b0)
		shStat = 8'h01;
		rd(IDX_ZERO_STATUS);
		rightZeroDetect <= 1'b1;
		waitc(6);
		`CHK(bipolarZeroHold, 1'b1)
		shStat = 8'h03;
		rd(IDX_ZERO_STATUS);
		wr(IDX_ZERO_ENABLE, 8'h00);
		waitc(6);
		`CHK(leftZeroPin, 1'b0)
		shStat = 8'h00;
		rd(IDX_ZERO_STATUS);
		wr(IDX_MODE_SELECT, 8'h20);
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_ZERO_ENABLE, {5'h0, 2'(c), 1'b0});
			waitc(6);
			`CHK(bitstreamZeroMode, 2'(c))
			`CHK(bipolarZeroHold, 1'b0)
			if (c == 0)
				`CHK(rightZeroPin, 1'b0)
		end
		wr(IDX_MODE_SELECT, 8'h10);
		wr(IDX_FILTER_CTRL, 8'h04);
		for (int k = 0; k < 6; k++)
		begin
			r = $random(seed);
			leftZeroPinIn <= r[0];
			rightZeroPinIn <= r[1];
			waitc(5);
			@(negedge clk);
			`CHK(bypassLeftData, r[0])
			`CHK(bypassRightData, r[1])
			`CHK(leftZeroPinOe, 1'b0)
			`CHK(converterSource, SRC_STEREO)
			@(posedge clk);
		end
		wr(IDX_ZERO_ENABLE, 8'h06);
		wr(IDX_MODE_SELECT, 8'h7f);
		fork
			host.idle();
			begin
				@(negedge clk);
				`CHK(softResetPulse, 1'b1)
			end
		join
		@(negedge clk);
		`CHK(softResetPulse, 1'b0)
		@(posedge clk);
		for (int i = 0; i < 3; i++)
			rd(IDX_FILTER_CTRL + 7'(i));
		chkMode();
		for (int n = 0; n < 20 && expQ.size() > 0; n++)
			@(posedge clk);
		if (expQ.size() > 0)
			`CHK(expQ.size(), 0)
		report_and_stop();
	end
endmodule
